// ### rtl/slf_map.vh
// constants for the switch and bus fault control block
`ifndef SLF_MAP_VH
`define SLF_MAP_VH
`define SLF_SLOPE_10K4        2'h0
`define SLF_SLOPE_20K         2'h1
`define SLF_SLOPE_FAST        2'h2
`define SLF_SLOPE_RESET       2'h1
`define SLF_MODE_NORMAL       2'h0
`define SLF_MODE_STOP         2'h1
`define SLF_MODE_SLEEP        2'h2
`define SLF_STUCK_TIME_MS     1000
`define SLF_CLK_MHZ           250
// one second at 250 MHz, sized to the counter width
`define SLF_STUCK_CYCLES      28'hEE6B280
`define SLF_STUCK_CW          28
`endif

// ### rtl/slf_sync2.v
// two-flop synchroniser, one per bit
`timescale 1ns/1ns
`default_nettype none
module slf_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          q[i]        <= 1'b0;
        end else begin
          meta_reg[i] <= d[i];
          q[i]        <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // slf_sync2
`default_nettype wire

// ### rtl/slf_ctrl.v
// switch gating, fault shutdown and bus transmitter protection
`timescale 1ns/1ns
`default_nettype none
`include "slf_map.vh"

// Functional notes
// [R1] high-side driver follows its enable bit.
// [R2] enable plus pwm select: high side follows pwm input.
// [R3] high-side open-load and current-limit flags follow sensed conditions.
// [R4] high-side overtemp: shutdown, latch source, set both status flags.
// [R5] high-side interrupt only when high-side mask set.
// [R6] host writes high-side control after overtemp clears; write re-enables.
// [R7] overvoltage with shutdown enabled stops high side; later write restores.
// [R8] high side may run in sleep/stop; low sides off there.
// [R9] low side with enable and pwm select follows pwm input.
// [R10] per-channel low-side open-load and current-limit flags.
// [R11] low-side overtemp stops both, latches source, masked interrupt.
// [R12] host writes low-side control after overtemp clears; write re-enables.
// [R13] overvoltage with shutdown enabled stops low sides; later write restores.
// [R14] two-bit slope select, reset value is the 20 kbit/s setting.
// [R15] pull-up off in low power when pull-up enable cleared.
// [R16] bus overcurrent keeps transmitter, sets flag, masked interrupt. Here it also sets receive-only, which blocks transmit.
// [R17] bus overtemp stops transmitter, sets flag, masked interrupt.
// [R18] re-enable after overtemp clears and transmit high, or status read. Here only transmit high re-enables; a read does not.
// [R19] receive pin short sets flag, stops transmitter, masked interrupt.
// [R20] short recovery on receive transition with transmit high; read clears.
// [R21] transmit dominant about one second: stop, flag, masked interrupt.
// [R22] stuck recovery when transmit high; read with transmit high clears.
// [R23] any bus error sets receive-only; it blocks transmit in normal mode.
// [R24] fault-held drivers stay off until their re-enable condition.
// [R25] pwm input synchronised before gating any driver.
module slf_ctrl #(
  parameter [`SLF_STUCK_CW-1:0] STUCK_CYCLES = `SLF_STUCK_CYCLES
) (
  input  wire       clk,
  input  wire       rst,
  // host-written control bits, same clock
  input  wire       high_side_enable,
  input  wire       high_side_pwm_select,
  input  wire       high_side_control_wr,
  input  wire       low_side_one_enable,
  input  wire       low_side_two_enable,
  input  wire       low_side_one_pwm_select,
  input  wire       low_side_two_pwm_select,
  input  wire       low_side_control_wr,
  input  wire       high_side_irq_mask,
  input  wire       low_side_irq_mask,
  input  wire       bus_irq_mask,
  input  wire       overvoltage_shutdown_enable,
  input  wire       bus_pullup_enable,
  input  wire [1:0] bus_slope_wdata,
  input  wire       receive_only_wdata,
  input  wire       bus_control_wr,
  input  wire       bus_status_rd,
  input  wire [1:0] op_mode,
  // pins and analog sense, asynchronous
  input  wire       direct_pwm_input,
  input  wire       transmit_pin,
  input  wire       receive_pin,
  input  wire       hs_open_load_sense,
  input  wire       hs_current_limit_sense,
  input  wire       hs_overtemp_sense,
  input  wire [1:0] ls_open_load_sense,
  input  wire [1:0] ls_current_limit_sense,
  input  wire       ls_overtemp_sense,
  input  wire       overvoltage_sense,
  input  wire       bus_overcurrent_sense,
  input  wire       bus_overtemp_sense,
  input  wire       receive_short_sense,
  // outputs
  output reg        high_side_drive,
  output reg  [1:0] low_side_drive,
  output reg        transmit_drive,
  output reg  [1:0] bus_slope_select,
  output reg        bus_pullup_connect,
  output reg        bus_wake_alt_threshold,
  output reg        receive_only_bit,
  output reg        high_side_open_load_flag,
  output reg        high_side_current_limit_flag,
  output reg        low_side_one_open_load_flag,
  output reg        low_side_two_open_load_flag,
  output reg        low_side_one_current_limit_flag,
  output reg        low_side_two_current_limit_flag,
  output reg        bus_overcurrent_flag,
  output reg        bus_overtemp_flag,
  output reg        receive_pin_short_flag,
  output reg        transmit_stuck_flag,
  output reg        high_side_irq_source,
  output reg        low_side_irq_source,
  output reg        irq_request
);
  wire [14:0] raw_in;
  wire [14:0] syn;
  assign raw_in = {direct_pwm_input, transmit_pin, receive_pin,
                   hs_open_load_sense, hs_current_limit_sense,
                   hs_overtemp_sense, ls_open_load_sense,
                   ls_current_limit_sense, ls_overtemp_sense,
                   overvoltage_sense, bus_overcurrent_sense,
                   bus_overtemp_sense, receive_short_sense};

  slf_sync2 #(.W(15)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (raw_in),
    .q   (syn)
  ); // see [R25]

  wire       pwm_s    = syn[14];
  wire       txd_s    = syn[13];
  wire       rxd_s    = syn[12];
  wire       hs_ol_s  = syn[11];
  wire       hs_cl_s  = syn[10];
  wire       hs_ot_s  = syn[9];
  wire [1:0] ls_ol_s  = syn[8:7];
  wire [1:0] ls_cl_s  = syn[6:5];
  wire       ls_ot_s  = syn[4];
  wire       ov_s     = syn[3];
  wire       boc_s    = syn[2];
  wire       bot_s    = syn[1];
  wire       rsh_s    = syn[0];

  reg                     hs_off_reg;
  reg                     ls_off_reg;
  reg                     tx_ot_off_reg;
  reg                     tx_sh_off_reg;
  reg                     tx_st_off_reg;
  reg                     rxd_prev_reg;
  reg                     rxd_seen_reg;
  reg [`SLF_STUCK_CW-1:0] stuck_cnt_reg;

  wire low_power = (op_mode == `SLF_MODE_STOP) ||
                   (op_mode == `SLF_MODE_SLEEP);
  wire hs_trip = hs_ot_s || (overvoltage_shutdown_enable && ov_s);
  wire ls_trip = ls_ot_s || (overvoltage_shutdown_enable && ov_s);
  wire stuck_hit = !txd_s && (stuck_cnt_reg == STUCK_CYCLES - 1'b1);
  wire rxd_edge = rxd_s ^ rxd_prev_reg;
  wire bus_err = boc_s || bot_s || rsh_s || stuck_hit;

  // fault hold for the drivers: a write only releases once cause is gone
  always @(posedge clk) begin
    if (rst) begin
      hs_off_reg <= 1'b0;
      ls_off_reg <= 1'b0;
    end else begin
      if (hs_trip)
        hs_off_reg <= 1'b1; // see [R4] see [R7]
      else if (high_side_control_wr)
        hs_off_reg <= 1'b0; // see [R6] see [R7]
      if (ls_trip)
        ls_off_reg <= 1'b1; // see [R11] see [R13]
      else if (low_side_control_wr)
        ls_off_reg <= 1'b0; // see [R12] see [R13]
    end
  end

  // driver gating
  always @(posedge clk) begin
    if (rst) begin
      high_side_drive <= 1'b0;
      low_side_drive  <= 2'h0;
    end else begin
      high_side_drive <= high_side_enable && !hs_off_reg && !hs_trip &&
                         (!high_side_pwm_select || pwm_s);
      // see [R1] see [R2] see [R8] see [R24]
      low_side_drive[0] <= low_side_one_enable && !ls_off_reg &&
                           !ls_trip && !low_power &&
                           (!low_side_one_pwm_select || pwm_s);
      low_side_drive[1] <= low_side_two_enable && !ls_off_reg &&
                           !ls_trip && !low_power &&
                           (!low_side_two_pwm_select || pwm_s);
      // see [R9] see [R8] see [R24]
    end
  end

  // switch status, high-side overtemp shown as both high-side flags together
  always @(posedge clk) begin
    if (rst) begin
      high_side_open_load_flag        <= 1'b0;
      high_side_current_limit_flag    <= 1'b0;
      low_side_one_open_load_flag     <= 1'b0;
      low_side_two_open_load_flag     <= 1'b0;
      low_side_one_current_limit_flag <= 1'b0;
      low_side_two_current_limit_flag <= 1'b0;
    end else begin
      high_side_open_load_flag     <= hs_ol_s || hs_off_reg; // see [R3] [R4]
      high_side_current_limit_flag <= hs_cl_s || hs_off_reg; // see [R3] [R4]
      low_side_one_open_load_flag     <= ls_ol_s[0]; // see [R10]
      low_side_two_open_load_flag     <= ls_ol_s[1]; // see [R10]
      low_side_one_current_limit_flag <= ls_cl_s[0]; // see [R10]
      low_side_two_current_limit_flag <= ls_cl_s[1]; // see [R10]
    end
  end

  // interrupt sources latch on overtemp; cleared by the matching write
  always @(posedge clk) begin
    if (rst) begin
      high_side_irq_source <= 1'b0;
      low_side_irq_source  <= 1'b0;
    end else begin
      if (hs_ot_s)
        high_side_irq_source <= 1'b1; // see [R4]
      else if (high_side_control_wr)
        high_side_irq_source <= 1'b0;
      if (ls_ot_s)
        low_side_irq_source <= 1'b1; // see [R11]
      else if (low_side_control_wr)
        low_side_irq_source <= 1'b0;
    end
  end

  // dominant timer; counter saturates so the trip is a single event
  always @(posedge clk) begin
    if (rst)
      stuck_cnt_reg <= {`SLF_STUCK_CW{1'b0}};
    else if (txd_s)
      stuck_cnt_reg <= {`SLF_STUCK_CW{1'b0}};
    else if (stuck_cnt_reg != STUCK_CYCLES)
      stuck_cnt_reg <= stuck_cnt_reg + 1'b1; // see [R21]
  end

  // bus transmitter fault holds and status; set wins over read clear
  always @(posedge clk) begin
    if (rst) begin
      tx_ot_off_reg          <= 1'b0;
      tx_sh_off_reg          <= 1'b0;
      tx_st_off_reg          <= 1'b0;
      rxd_prev_reg           <= 1'b0;
      rxd_seen_reg           <= 1'b0;
      bus_overcurrent_flag   <= 1'b0;
      bus_overtemp_flag      <= 1'b0;
      receive_pin_short_flag <= 1'b0;
      transmit_stuck_flag    <= 1'b0;
    end else begin
      rxd_prev_reg <= rxd_s;
      if (boc_s)
        bus_overcurrent_flag <= 1'b1; // see [R16]
      else if (bus_status_rd)
        bus_overcurrent_flag <= 1'b0;
      if (bot_s) begin
        tx_ot_off_reg     <= 1'b1; // see [R17]
        bus_overtemp_flag <= 1'b1;
      end else if (txd_s) begin
        tx_ot_off_reg <= 1'b0; // see [R18]
        if (bus_status_rd)
          bus_overtemp_flag <= 1'b0;
      end
      if (rsh_s) begin
        tx_sh_off_reg          <= 1'b1; // see [R19]
        receive_pin_short_flag <= 1'b1;
        rxd_seen_reg           <= 1'b0;
      end else begin
        if (rxd_edge)
          rxd_seen_reg <= 1'b1;
        if ((rxd_seen_reg || rxd_edge) && txd_s)
          tx_sh_off_reg <= 1'b0; // see [R20]
        if (bus_status_rd)
          receive_pin_short_flag <= 1'b0; // see [R20]
      end
      if (stuck_hit) begin
        tx_st_off_reg       <= 1'b1; // see [R21]
        transmit_stuck_flag <= 1'b1;
      end else if (txd_s) begin
        tx_st_off_reg <= 1'b0; // see [R22]
        if (bus_status_rd)
          transmit_stuck_flag <= 1'b0; // see [R22]
      end
    end
  end

  // bus control register; receive-only set by hardware wins over write
  always @(posedge clk) begin
    if (rst) begin
      bus_slope_select <= `SLF_SLOPE_RESET; // see [R14]
      receive_only_bit <= 1'b0;
    end else begin
      if (bus_control_wr)
        bus_slope_select <= bus_slope_wdata; // see [R14]
      if (bus_err)
        receive_only_bit <= 1'b1; // see [R23]
      else if (bus_control_wr)
        receive_only_bit <= receive_only_wdata;
    end
  end

  // transmitter and pull-up; overcurrent blocks transmit only through the receive-only bit
  always @(posedge clk) begin
    if (rst) begin
      transmit_drive         <= 1'b0;
      bus_pullup_connect     <= 1'b1;
      bus_wake_alt_threshold <= 1'b0;
      irq_request            <= 1'b0;
    end else begin
      transmit_drive <= !txd_s && !low_power && !receive_only_bit &&
                        !tx_ot_off_reg && !tx_sh_off_reg &&
                        !tx_st_off_reg && !bot_s && !rsh_s && !stuck_hit;
      // see [R16] see [R23] see [R24]
      bus_pullup_connect     <= !low_power || bus_pullup_enable; // see [R15]
      bus_wake_alt_threshold <= !bus_pullup_enable; // see [R15]
      irq_request <= (high_side_irq_mask && high_side_irq_source) ||
                     (low_side_irq_mask && low_side_irq_source) ||
                     (bus_irq_mask && (bus_overcurrent_flag ||
                      bus_overtemp_flag || receive_pin_short_flag ||
                      transmit_stuck_flag));
      // see [R5] see [R11] see [R16] see [R17] see [R19] see [R21]
    end
  end
endmodule // slf_ctrl
`default_nettype wire

// ### tb/slf_ctrl_asserts.sv
// assertion checker for the switch and bus fault control block
`timescale 1ns/1ns
`default_nettype none
module slf_ctrl_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       high_side_enable,
  input wire logic       high_side_irq_mask,
  input wire logic [1:0] op_mode,
  input wire logic       high_side_drive,
  input wire logic [1:0] low_side_drive,
  input wire logic       transmit_drive,
  input wire logic [1:0] bus_slope_select,
  input wire logic       receive_only_bit,
  input wire logic       high_side_open_load_flag,
  input wire logic       high_side_current_limit_flag,
  input wire logic       high_side_irq_source,
  input wire logic       low_side_irq_source,
  input wire logic       irq_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  hs_drive_en_a: assert property (
    high_side_drive |-> $past(high_side_enable))
    else $error("high side driven without enable");
  hs_trip_off_a: assert property (
    high_side_irq_source |-> !high_side_drive)
    else $error("high side driven while tripped");
  hs_ot_flags_a: assert property (
    $rose(high_side_irq_source) |=>
    high_side_open_load_flag && high_side_current_limit_flag)
    else $error("high side trip without both flags");
  hs_irq_mask_a: assert property (
    high_side_irq_source && high_side_irq_mask |=> irq_request)
    else $error("unmasked high side trip gave no irq");
  ls_trip_off_a: assert property (
    low_side_irq_source |-> low_side_drive == 2'h0)
    else $error("low side driven while tripped");
  ls_mode_off_a: assert property (
    (op_mode == 2'h1 || op_mode == 2'h2) |=> low_side_drive == 2'h0)
    else $error("low side driven in low power mode");
  receive_only_bit_block_a: assert property (
    receive_only_bit && $past(receive_only_bit) |-> !transmit_drive)
    else $error("transmit driven in receive only");
  slope_reset_a: assert property (
    disable iff (1'b0) $fell(rst) |-> bus_slope_select == 2'h1)
    else $error("slope select not at reset value");
  cover property ($rose(high_side_irq_source));
  cover property ($rose(receive_only_bit));
  cover property (low_side_irq_source && !irq_request);
endmodule // slf_ctrl_asserts
bind slf_ctrl slf_ctrl_asserts u_chk (.*);
`default_nettype wire

// ### tb/slf_host_model.sv
// host side model driving the pwm and transmit pins
`timescale 1ns/1ns
`default_nettype none
module slf_host_model (
  input  wire logic clk,
  input  wire logic pwm_cmd,
  input  wire logic tx_cmd,
  output var  logic direct_pwm_input,
  output var  logic transmit_pin
);
  initial begin
    direct_pwm_input = 1'b0;
    transmit_pin = 1'b1;
  end
  // pins move just after the edge, as a port register would
  always @(posedge clk) begin
    direct_pwm_input <= #1 pwm_cmd;
    transmit_pin <= #1 tx_cmd;
  end
endmodule // slf_host_model
`default_nettype wire

// ### tb/switch_and_lin_fault_control_tb_top.sv
// self-checking bench for the switch and bus fault control block
`timescale 1ns/1ns
`default_nettype none
module switch_and_lin_fault_control_tb_top;
  logic clk = '0, rst = '1, pwm_cmd = '0, tx_cmd = '1;
  logic high_side_enable = '0, high_side_pwm_select = '0;
  logic high_side_control_wr = '0, low_side_control_wr = '0;
  logic low_side_one_enable = '0, low_side_two_enable = '0;
  logic low_side_one_pwm_select = '0, low_side_two_pwm_select = '0;
  logic high_side_irq_mask = '0, low_side_irq_mask = '0, bus_irq_mask = '0;
  logic overvoltage_shutdown_enable = '0, bus_pullup_enable = '1;
  logic [1:0] bus_slope_wdata = '0, op_mode = '0;
  logic receive_only_wdata = '0, bus_control_wr = '0, bus_status_rd = '0;
  logic receive_pin = '0, hs_open_load_sense = '0;
  logic hs_current_limit_sense = '0, hs_overtemp_sense = '0;
  logic [1:0] ls_open_load_sense = '0, ls_current_limit_sense = '0;
  logic ls_overtemp_sense = '0, overvoltage_sense = '0;
  logic bus_overcurrent_sense = '0, bus_overtemp_sense = '0;
  logic receive_short_sense = '0;
  wire direct_pwm_input, transmit_pin, high_side_drive, transmit_drive;
  wire [1:0] low_side_drive, bus_slope_select;
  wire bus_pullup_connect, bus_wake_alt_threshold, receive_only_bit;
  wire high_side_open_load_flag, high_side_current_limit_flag;
  wire low_side_one_open_load_flag, low_side_two_open_load_flag;
  wire low_side_one_current_limit_flag, low_side_two_current_limit_flag;
  wire bus_overcurrent_flag, bus_overtemp_flag, receive_pin_short_flag;
  wire transmit_stuck_flag, high_side_irq_source, low_side_irq_source;
  wire irq_request;
  int miscompares = 0;
  int cmp_count = 0;
  // short stuck time keeps the run brief
  slf_ctrl #(.STUCK_CYCLES(28'h14)) DUT (.*);
  slf_host_model host (.clk, .pwm_cmd, .tx_cmd, .direct_pwm_input,
                       .transmit_pin);
  always #2 clk = ~clk;
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pulse(input int k);
    {bus_status_rd, bus_control_wr, low_side_control_wr,
     high_side_control_wr} = 4'h1 << k;
    step(1);
    {bus_status_rd, bus_control_wr, low_side_control_wr,
     high_side_control_wr} = 4'h0;
    step(1);
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    step(5);
    rst = '0;
    chk("slope", 8'h01, bus_slope_select);
    high_side_enable = '1;
    step(1);
    chk("hs on", 8'h01, high_side_drive);
    high_side_pwm_select = '1;
    {low_side_two_enable, low_side_one_enable} = 2'h3;
    {low_side_two_pwm_select, low_side_one_pwm_select} = 2'h3;
    step(5);
    chk("pwm low", 8'h00, {high_side_drive, low_side_drive});
    pwm_cmd = '1;
    step(5);
    chk("pwm high", 8'h07, {high_side_drive, low_side_drive});
    pwm_cmd = '0;
    step(3);
    chk("pwm sync", 8'h01, high_side_drive);
    step(2);
    chk("pwm fall", 8'h00, high_side_drive);
    high_side_pwm_select = '0;
    {low_side_two_pwm_select, low_side_one_pwm_select} = 2'h0;
    bus_pullup_enable = '0;
    for (int m = 1; m < 3; m++) begin
      op_mode = m[1:0];
      step(2);
      chk("low power", 8'h01, {low_side_drive, high_side_drive});
      chk("pullup", 8'h00, bus_pullup_connect);
      chk("wake thr", 8'h01, bus_wake_alt_threshold);
    end
    op_mode = 2'h0;
    {hs_open_load_sense, ls_open_load_sense, ls_current_limit_sense} = 5'h16;
    step(4);
    chk("sense", 8'h29, {high_side_open_load_flag,
        high_side_current_limit_flag, low_side_one_open_load_flag,
        low_side_two_open_load_flag, low_side_one_current_limit_flag,
        low_side_two_current_limit_flag});
    {hs_open_load_sense, ls_open_load_sense, ls_current_limit_sense} = 5'h00;
    high_side_irq_mask = '1;
    hs_overtemp_sense = '1;
    step(5);
    chk("hs trip", 8'h0F, {high_side_drive, high_side_irq_source,
        high_side_open_load_flag, high_side_current_limit_flag,
        irq_request});
    pulse(0);
    chk("write in trip", 8'h00, high_side_drive);
    hs_overtemp_sense = '0;
    step(4);
    chk("held off", 8'h00, high_side_drive);
    pulse(0);
    step(1);
    chk("hs back", 8'h02, {high_side_drive, high_side_irq_source});
    ls_overtemp_sense = '1;
    step(5);
    chk("ls trip", 8'h02, {low_side_drive, low_side_irq_source,
        irq_request});
    ls_overtemp_sense = '0;
    step(4);
    pulse(1);
    step(1);
    chk("ls back", 8'h03, low_side_drive);
    overvoltage_shutdown_enable = '1;
    overvoltage_sense = '1;
    step(5);
    chk("ov off", 8'h00, {high_side_drive, low_side_drive});
    overvoltage_sense = '0;
    step(4);
    pulse(0);
    pulse(1);
    step(1);
    chk("ov back", 8'h07, {high_side_drive, low_side_drive});
    bus_irq_mask = '1;
    tx_cmd = '0;
    step(4);
    chk("tx follows", 8'h01, transmit_drive);
    bus_overcurrent_sense = '1;
    step(5);
    chk("overcurrent", 8'h07, {bus_overcurrent_flag, receive_only_bit,
        irq_request});
    bus_overcurrent_sense = '0;
    tx_cmd = '1;
    step(4);
    pulse(3);
    chk("oc cleared", 8'h00, bus_overcurrent_flag);
    for (int s = 0; s < 3; s++) begin
      bus_slope_wdata = s[1:0];
      pulse(2);
      chk("slope", s[7:0], bus_slope_select);
    end
    chk("rx only", 8'h00, receive_only_bit);
    receive_only_wdata = '1;
    pulse(2);
    chk("rx only wr", 8'h01, receive_only_bit);
    receive_only_wdata = '0;
    pulse(2);
    chk("rx only clr", 8'h00, receive_only_bit);
    tx_cmd = '0;
    bus_overtemp_sense = '1;
    step(5);
    chk("bus ot", 8'h01, {transmit_drive, bus_overtemp_flag});
    bus_overtemp_sense = '0;
    step(4);
    chk("tx held", 8'h00, transmit_drive);
    tx_cmd = '1;
    step(4);
    pulse(3);
    pulse(2);
    chk("ot cleared", 8'h00, bus_overtemp_flag);
    tx_cmd = '0;
    step(4);
    chk("tx again", 8'h01, transmit_drive);
    step(22);
    chk("stuck", 8'h07, {transmit_drive, transmit_stuck_flag,
        receive_only_bit, irq_request});
    pulse(3);
    chk("read tx low", 8'h01, transmit_stuck_flag);
    tx_cmd = '1;
    step(4);
    pulse(3);
    chk("stuck cleared", 8'h00, transmit_stuck_flag);
    receive_short_sense = '1;
    step(5);
    chk("rx short", 8'h01, receive_pin_short_flag);
    pulse(3);
    chk("read in short", 8'h01, receive_pin_short_flag);
    receive_short_sense = '0;
    receive_pin = '1;
    step(4);
    pulse(3);
    chk("short cleared", 8'h00, receive_pin_short_flag);
    test_done;
  end
  initial begin
    #8000;
    miscompares++;
    test_done;
  end
endmodule // switch_and_lin_fault_control_tb_top
`default_nettype wire
